// >>> aqs_sequencer.sv
// Acquisition qualify sequencer: decides which sampled bus cycles of the
// system under test go to acquisition memory, via a two-entry buffer.
// Assumes pclk much faster than the sampled bus clock; APB register access.
//
// Overview of operation
// - With qualification in use, store only cycles where a store action executes.
// - Store actions may sit in any test, many times, each gated by its own test.
// - Any store action in a live clause (kind not never) means ungated cycles are never stored.
// - Acquisition ends when the post-trigger counter hits its target; stored cycles only.
// - Without further stored cycles the run continues until the operator stops it.
// - Matching write cycles are stored and counted; counter condition true at target 100.
// - Counter condition fires trigger, stores trigger cycle, moves to next test.
// - Mid-window position: after the trigger cycle, 127 more stored cycles.
// - Matcher read/write field 0 matches writes only; don't-care matches anything.
// - A test with only an always clause holding store stores every cycle.
`timescale 1ns/1ps
module aqs_sequencer #(
   parameter int NUM_TESTS = 4,
   parameter int NUM_MATCH = 4,
   parameter int CNT_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sut_clk,
   input wire aqs_pkg::aqs_sample_t sut_bus,
   output logic acq_valid,
   input wire logic acq_ready,
   output aqs_pkg::aqs_rec_t acq_data,
   output logic running
);
   import aqs_pkg::*;

   // Elaboration check: goto and matcher index are two bits wide
   if (NUM_TESTS < 1 || NUM_TESTS > 4 || NUM_MATCH < 1 || NUM_MATCH > 4 || CNT_W < 8 || CNT_W > 16) begin : g_chk
      $error("aqs_sequencer: unsupported parameter values");
   end

   localparam int PROG_N = NUM_TESTS * CLAUSES;

   aqs_state_t state_r;
   logic [1:0] tst_r;
   logic trig_r;
   logic ovr_r;
   logic [CNT_W-1:0] evt_cnt_r;
   logic [CNT_W-1:0] post_cnt_r;
   logic [CNT_W-1:0] cnt_tgt_r;
   logic [CNT_W-1:0] dly_tgt_r;
   logic [CLAUSE_W-1:0] prog_r [PROG_N];
   logic [31:0] mw0_r [NUM_MATCH];
   logic [31:0] mw1_r [NUM_MATCH];
   logic [2:0] clk_sync_r;
   aqs_sample_t bus_s1_r;
   aqs_sample_t bus_s2_r;
   aqs_sample_t smp_r;
   logic pend_r;
   logic qual_used;

   // Pattern match; a mask bit of zero means don't-care
   function automatic logic hit_match(aqs_sample_t s, logic [31:0] w0, logic [31:0] w1);
      logic a_ok;
      logic d_ok;
      logic r_ok;
      a_ok = ((s.addr ^ w0[15:0]) & w0[31:16]) == 16'h0000;
      d_ok = ((s.data ^ w1[7:0]) & w1[M_DMASK+:8]) == 8'h00;
      r_ok = !w1[M_RW_CARE] || (s.rw == w1[M_RW_VAL]);
      return a_ok && d_ok && r_ok;
   endfunction : hit_match

   // Program slot of a test's clause
   function automatic int slot(logic [1:0] t, int c);
      return int'(t) * CLAUSES + c;
   endfunction : slot

   // APB decode
   logic [7:0] off;
   logic hi_zero;
   logic in_match;
   logic in_prog;
   logic [1:0] m_sel;
   logic [1:0] p_tst;
   logic [1:0] p_cl;
   logic mapped;
   logic apb_wr;
   assign off = paddr[7:0];
   assign hi_zero = paddr[31:8] == 24'h000000;
   assign in_match = off >= A_MATCH_BASE && off < A_MATCH_BASE + 8'(NUM_MATCH) * MATCH_STRIDE;
   assign in_prog = off >= A_PROG_BASE && off < A_PROG_BASE + 8'(NUM_TESTS) * TEST_STRIDE
                    && p_cl != 2'(CLAUSES);
   assign m_sel = off[4:3];
   assign p_tst = off[5:4];
   assign p_cl = off[3:2];
   assign mapped = hi_zero && off[1:0] == 2'b00 && (in_match || in_prog || off == A_CTRL
                   || off == A_STATUS || off == A_CNT_TGT || off == A_DLY_TGT
                   || off == A_EVT_CNT || off == A_POST_CNT);
   assign apb_wr = psel && penable && pwrite && mapped;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Read mux; zero for unmapped and reserved bits, except matcher words, which read back all 32 written bits
   always_comb begin
      prdata = 32'h0;
      if (mapped) begin
         if (in_match) begin
            prdata = off[2] ? mw1_r[m_sel] : mw0_r[m_sel];
         end else if (in_prog) begin
            prdata = 32'(prog_r[slot(p_tst, int'(p_cl))]);
         end else begin
            case (off)
               A_STATUS: begin
                  prdata[STS_STATE+:3] = state_r;
                  prdata[STS_TRIG] = trig_r;
                  prdata[STS_OVR] = ovr_r;
                  prdata[STS_QUAL] = qual_used;
                  prdata[STS_TEST+:2] = tst_r;
               end
               A_CNT_TGT: prdata = 32'(cnt_tgt_r);
               A_DLY_TGT: prdata = 32'(dly_tgt_r);
               A_EVT_CNT: prdata = 32'(evt_cnt_r);
               A_POST_CNT: prdata = 32'(post_cnt_r);
               default: prdata = 32'h0;
            endcase
         end
      end
   end

   // Configuration registers: targets, matchers, program
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_tgt_r <= CNT_W'(CNT_TGT_RST);
         dly_tgt_r <= CNT_W'(DLY_TGT_RST);
         for (int i = 0; i < NUM_MATCH; i++) begin
            mw0_r[i] <= 32'h0;
            mw1_r[i] <= 32'h0;
         end
         for (int i = 0; i < PROG_N; i++) begin
            prog_r[i] <= '0;
         end
      end else if (apb_wr) begin
         if (off == A_CNT_TGT) cnt_tgt_r <= pwdata[CNT_W-1:0];
         if (off == A_DLY_TGT) dly_tgt_r <= pwdata[CNT_W-1:0];
         if (in_match && !off[2]) mw0_r[m_sel] <= pwdata;
         if (in_match && off[2]) mw1_r[m_sel] <= pwdata;
         if (in_prog) prog_r[slot(p_tst, int'(p_cl))] <= pwdata[CLAUSE_W-1:0];
      end
   end

   // Pin synchronisers; third clock flop only feeds the edge detector
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_sync_r <= 3'b000;
         bus_s1_r <= '0;
         bus_s2_r <= '0;
      end else begin
         clk_sync_r <= {clk_sync_r[1:0], sut_clk};
         bus_s1_r <= sut_bus;
         bus_s2_r <= bus_s1_r;
      end
   end

   logic smp_stb;
   assign smp_stb = clk_sync_r[1] && !clk_sync_r[2];

   // Qualification is in force if any live clause holds a store action
   always_comb begin
      aqs_clause_t q;
      q = '0;
      qual_used = 1'b0;
      for (int i = 0; i < PROG_N; i++) begin
         q = aqs_clause_t'(prog_r[i]);
         qual_used = qual_used || (q.store && q.kind != K_NEVER);
      end
   end

   // Clause evaluation for the active test; first true clause acts
   aqs_clause_t cl [CLAUSES];
   logic [CLAUSES-1:0] tru;
   aqs_clause_t act;
   logic act_ok;
   always_comb begin
      act = '0;
      act_ok = 1'b0;
      for (int c = 0; c < CLAUSES; c++) begin
         cl[c] = aqs_clause_t'(prog_r[slot(tst_r, c)]);
         case (cl[c].kind)
            K_MATCH: tru[c] = hit_match(smp_r, mw0_r[cl[c].midx], mw1_r[cl[c].midx]);
            K_COUNT: tru[c] = evt_cnt_r == cnt_tgt_r;
            K_ALWAYS: tru[c] = 1'b1;
            default: tru[c] = 1'b0;
         endcase
      end
      for (int c = CLAUSES - 1; c >= 0; c--) begin
         if (tru[c]) begin
            act = cl[c];
            act_ok = 1'b1;
         end
      end
   end

   // One evaluation per sample; stalls while the buffer is full
   logic eval;
   logic do_store;
   logic do_trig;
   logic post_hit;
   logic buf_rdy;
   assign eval = state_r == ST_RUN && pend_r && buf_rdy;
   assign do_store = eval && (qual_used ? (act_ok && act.store) : 1'b1);
   assign do_trig = eval && act_ok && act.trig && !trig_r;
   assign post_hit = do_store && trig_r && post_cnt_r + 1'b1 == dly_tgt_r;

   // Latched sample held until evaluated
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smp_r <= '0;
         pend_r <= 1'b0;
         ovr_r <= 1'b0;
      end else begin
         if (smp_stb && !(pend_r && !eval)) begin
            smp_r <= bus_s2_r;
         end
         if (smp_stb) pend_r <= state_r == ST_RUN;
         else if (eval || state_r != ST_RUN) pend_r <= 1'b0;
         if (apb_wr && off == A_CTRL && pwdata[CTRL_START]) ovr_r <= 1'b0;
         if (smp_stb && pend_r && !eval) ovr_r <= 1'b1; // Lost sample wins over clear
      end
   end

   // Run control, test transfer, trigger
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         tst_r <= 2'b00;
         trig_r <= 1'b0;
      end else if (apb_wr && off == A_CTRL && pwdata[CTRL_STOP]) begin
         state_r <= ST_DONE;
      end else if (apb_wr && off == A_CTRL && pwdata[CTRL_START]) begin
         state_r <= ST_RUN;
         tst_r <= 2'b00;
         trig_r <= 1'b0;
      end else begin
         case (state_r)
            ST_RUN: begin
               if (post_hit) state_r <= ST_DONE;
               if (do_trig) trig_r <= 1'b1;
               if (eval && act_ok && act.gto_en) tst_r <= act.gto;
            end
            ST_IDLE, ST_DONE: state_r <= state_r;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Event and post-trigger counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_cnt_r <= '0;
         post_cnt_r <= '0;
      end else if (apb_wr && off == A_CTRL && pwdata[CTRL_START]) begin
         evt_cnt_r <= '0;
         post_cnt_r <= '0;
      end else begin
         if (eval && act_ok && act.count) evt_cnt_r <= evt_cnt_r + 1'b1;
         if (do_store && trig_r) post_cnt_r <= post_cnt_r + 1'b1;
      end
   end

   // Two-entry buffer toward acquisition memory; a long stall loses later samples and sets overrun
   aqs_rec_t buf_r [2];
   logic wp_r;
   logic rp_r;
   logic [1:0] cnt_r;
   logic push;
   logic pop;
   assign buf_rdy = cnt_r != 2'd2;
   assign push = do_store;
   assign pop = acq_valid && acq_ready;
   assign acq_valid = cnt_r != 2'd0;
   assign acq_data = buf_r[rp_r];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_r[0] <= '0;
         buf_r[1] <= '0;
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'd0;
      end else begin
         if (push) begin
            buf_r[wp_r] <= '{trig: do_trig, s: smp_r};
            wp_r <= !wp_r;
         end
         if (pop) rp_r <= !rp_r;
         cnt_r <= cnt_r + 2'(push) - 2'(pop);
      end
   end

   assign running = state_r == ST_RUN;

   // Checks
   a_gated_store: assert property (@(posedge pclk) disable iff (!presetn)
      eval && qual_used && !(act_ok && act.store) |-> !push)
      else $error("ungated cycle stored");
   a_no_store_idle: assert property (@(posedge pclk) disable iff (!presetn)
      state_r != ST_RUN |-> !push)
      else $error("store outside run");
   a_delay_done: assert property (@(posedge pclk) disable iff (!presetn)
      post_hit && !apb_wr |=> state_r == ST_DONE && post_cnt_r == $past(dly_tgt_r))
      else $error("delay end missed");
   a_post_on_store: assert property (@(posedge pclk) disable iff (!presetn)
      !(apb_wr && off == A_CTRL) ##1 post_cnt_r != $past(post_cnt_r) |-> $past(push) && $past(trig_r))
      else $error("post count moved without store");
   a_keep_running: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == ST_RUN && !post_hit && !apb_wr |=> state_r == ST_RUN)
      else $error("run ended without cause");
   a_evt_count: assert property (@(posedge pclk) disable iff (!presetn)
      eval && act_ok && act.count && !apb_wr |=> evt_cnt_r == $past(evt_cnt_r) + 1'b1)
      else $error("event not counted");
   a_trig_stored: assert property (@(posedge pclk) disable iff (!presetn)
      do_trig && act.store |-> push ##1 trig_r)
      else $error("trigger cycle not stored");
   a_write_only: assert property (@(posedge pclk) disable iff (!presetn)
      cl[0].kind == K_MATCH && mw1_r[cl[0].midx][M_RW_CARE] && !mw1_r[cl[0].midx][M_RW_VAL]
      && smp_r.rw |-> !tru[0])
      else $error("read matched write pattern");
   a_one_eval: assert property (@(posedge pclk) disable iff (!presetn)
      eval && !smp_stb |=> !eval)
      else $error("sample evaluated twice");
   a_goto_next: assert property (@(posedge pclk) disable iff (!presetn)
      eval && act_ok && act.gto_en && !apb_wr |=> tst_r == $past(act.gto))
      else $error("test transfer missed");
   a_always_store: assert property (@(posedge pclk) disable iff (!presetn)
      eval && act_ok && act.kind == K_ALWAYS && act.store |-> push)
      else $error("always clause did not store");
   a_buf_hold: assert property (@(posedge pclk) disable iff (!presetn)
      acq_valid && !acq_ready |=> acq_valid && $stable(acq_data))
      else $error("buffer dropped a word");
endmodule : aqs_sequencer

// >>> aqs_pkg.sv
// Package for the acquisition qualify sequencer: register map, field
// positions, reset values, program word layout, carrier structs, states.
// Assumes a 32-bit APB slave and a sampled 8-bit-data/16-bit-address bus.
package aqs_pkg;
   // Register byte addresses
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_CNT_TGT = 8'h08;
   localparam logic [7:0] A_DLY_TGT = 8'h0c;
   localparam logic [7:0] A_EVT_CNT = 8'h10;
   localparam logic [7:0] A_POST_CNT = 8'h14;
   localparam logic [7:0] A_MATCH_BASE = 8'h20;
   localparam logic [7:0] A_PROG_BASE = 8'h40;
   localparam logic [7:0] MATCH_STRIDE = 8'h08;
   localparam logic [7:0] TEST_STRIDE = 8'h10;
   localparam int CLAUSES = 3;
   // Control bits (write one for a one-cycle command)
   localparam int CTRL_START = 0;
   localparam int CTRL_STOP = 1;
   // Status bit positions
   localparam int STS_STATE = 0;
   localparam int STS_TRIG = 3;
   localparam int STS_OVR = 4;
   localparam int STS_QUAL = 5;
   localparam int STS_TEST = 8;
   // Matcher second word fields
   localparam int M_DMASK = 8;
   localparam int M_RW_VAL = 16;
   localparam int M_RW_CARE = 17;
   // Reset values: event target 100, mid-window post-trigger count 127
   localparam logic [15:0] CNT_TGT_RST = 16'h0064;
   localparam logic [15:0] DLY_TGT_RST = 16'h007f;
   localparam int CLAUSE_W = 10;

   typedef enum logic [1:0] {
      K_NEVER = 2'h0,
      K_MATCH = 2'h1,
      K_COUNT = 2'h2,
      K_ALWAYS = 2'h3
   } aqs_kind_t;

   // Program clause: condition plus its compound action
   typedef struct packed {
      logic [1:0] gto;
      logic gto_en;
      logic trig;
      logic count;
      logic store;
      logic [1:0] midx;
      aqs_kind_t kind;
   } aqs_clause_t;

   // Sampled cycle; rw high is a read, low a write
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
      logic rw;
   } aqs_sample_t;

   typedef struct packed {
      logic trig;
      aqs_sample_t s;
   } aqs_rec_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_DONE = 3'b100
   } aqs_state_t;
endpackage : aqs_pkg

// >>> aqs_bus_model.sv
// Model of the sampled processor bus: one bus cycle every ten pclk.
// Assumes pclk at 50 MHz; the bus is held six pclk before and four pclk after each sut_clk rise.
`timescale 1ns/1ps
module aqs_bus_model (
   input wire logic pclk,
   input wire logic go,
   input wire logic [1:0] mode,
   output logic sut_clk,
   output aqs_pkg::aqs_sample_t sut_bus
);
   import aqs_pkg::*;
   logic [3:0] ph_r;
   logic [15:0] n_r;

   // Phase and cycle count restart when idle, so every run begins at address 0
   always_ff @(posedge pclk) begin
      if (!go) begin
         ph_r <= 4'h0;
         n_r <= 16'h0;
         sut_clk <= 1'b0;
      end else begin
         ph_r <= (ph_r == 4'h9) ? 4'h0 : ph_r + 4'h1;
         if (ph_r == 4'h5) sut_clk <= 1'b1;
         if (ph_r == 4'h0) sut_clk <= 1'b0;
         if (ph_r == 4'h9) n_r <= n_r + 16'h1;
      end
   end

   // Mode 0 all writes, 1 alternating from a write, 2 all reads
   assign sut_bus = '{addr: n_r, data: n_r[7:0] ^ 8'h5a,
                      rw: (mode == 2'h0) ? 1'b0 : (mode == 2'h1) ? n_r[0] : 1'b1};
endmodule : aqs_bus_model

// >>> test_acquisition_qualify_sequencer.sv
// Self-checking bench for aqs_sequencer: APB master, bus model, stalling memory side.
// Assumes the zero-wait APB slave and the register map of aqs_pkg.
`timescale 1ns/1ps
module test_acquisition_qualify_sequencer;
   import aqs_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata, r;
   logic sut_clk, acq_valid, acq_ready, running, go, hold, e;
   logic [1:0] mode;
   logic [2:0] cyc;
   aqs_sample_t sut_bus;
   aqs_rec_t acq_data, x;
   aqs_rec_t recs[$];
   int fail_count, checks;

   aqs_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sut_clk(sut_clk),
      .sut_bus(sut_bus), .acq_valid(acq_valid), .acq_ready(acq_ready), .acq_data(acq_data), .running(running));
   aqs_bus_model u_bus (.pclk(pclk), .go(go), .mode(mode), .sut_clk(sut_clk), .sut_bus(sut_bus));

   // Clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // Memory side refuses one cycle in eight unless held; records logged at handshake
   always @(posedge pclk) begin
      cyc <= cyc + 3'h1;
      acq_ready <= !hold && (cyc != 3'h0);
      if (acq_valid === 1'b1 && acq_ready === 1'b1) recs.push_back(acq_data);
   end

   task automatic final_report();
      if (fail_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; answer taken at the edge where pready is seen high
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Access phase ends at the rising edge where pready is seen high
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) begin
         fail_count++;
         final_report();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(r, exp);
   endtask : rd

   task automatic prog(input int t, input int c, input logic [31:0] v);
      apb(1'b1, {24'h0, A_PROG_BASE} + 32'(16 * t + 4 * c), v);
   endtask : prog

   // Bounded wait until the run has ended and the buffer is empty
   task automatic settle(input int lim);
      int n;
      n = 0;
      // Look first after an edge, so a command just issued has landed
      do begin
         @(negedge pclk);
         n++;
         if (n > lim) begin
            fail_count++;
            final_report();
         end
      end while ((running | acq_valid) !== 1'b0);
   endtask : settle

   task automatic run(input logic [1:0] m);
      recs.delete();
      mode <= m;
      apb(1'b1, {24'h0, A_CTRL}, 32'h1);
      go <= 1'b1;
   endtask : run

   task automatic t_reset();
      rd({24'h0, A_STATUS}, 32'h1);
      rd({24'h0, A_CNT_TGT}, 32'h64);
      rd({24'h0, A_DLY_TGT}, 32'h7f);
      apb(1'b0, 32'h4c, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
   endtask : t_reset

   // Store writes and count them; trigger on the counter; then store everything
   task automatic t_example();
      apb(1'b1, {24'h0, A_MATCH_BASE} + 32'h4, 32'h20000);
      prog(0, 0, 32'h31);
      prog(0, 1, 32'h1d2);
      prog(1, 0, 32'h13);
      run(2'h1);
      settle(20000);
      go <= 1'b0;
      chk(32'(recs.size()), 32'd228);
      for (int i = 0; i < recs.size() && i < 228; i++) begin
         x.s.addr = (i < 100) ? 16'(2 * i) : 16'(99 + i);
         x.s.data = x.s.addr[7:0] ^ 8'h5a;
         x.s.rw = x.s.addr[0];
         x.trig = (i == 100);
         chk(32'(recs[i]), 32'(x));
      end
      rd({24'h0, A_STATUS}, 32'h12c);
      rd({24'h0, A_EVT_CNT}, 32'd100);
      rd({24'h0, A_POST_CNT}, 32'd127);
   endtask : t_example

   // Nothing stored after the trigger: run only ends on stop
   task automatic t_stop();
      apb(1'b1, {24'h0, A_MATCH_BASE} + 32'h8, 32'hffff0005);
      apb(1'b1, {24'h0, A_MATCH_BASE} + 32'h10, 32'hffffbeef);
      prog(0, 0, 32'h1d5);
      prog(0, 1, 32'h0);
      prog(1, 0, 32'h19);
      run(2'h0);
      repeat (2000) @(posedge pclk);
      chk({31'h0, running}, 32'h1);
      rd({24'h0, A_STATUS}, 32'h12a);
      x = '0;
      x.trig = 1'b1;
      x.s.addr = 16'h5;
      x.s.data = 8'h5f;
      chk(32'(recs.size()), 32'd1);
      if (recs.size() > 0) chk(32'(recs[0]), 32'(x));
      apb(1'b1, {24'h0, A_CTRL}, 32'h2);
      settle(100);
      go <= 1'b0;
      rd({24'h0, A_STATUS}, 32'h12c);
   endtask : t_stop

   // Memory held off: buffer fills, overrun flagged, drained in order
   task automatic t_stall();
      prog(0, 0, 32'h0);
      prog(1, 0, 32'h0);
      hold <= 1'b1;
      run(2'h0);
      repeat (100) @(posedge pclk);
      chk({31'h0, acq_valid}, 32'h1);
      rd({24'h0, A_STATUS}, 32'h12);
      apb(1'b1, {24'h0, A_CTRL}, 32'h2);
      go <= 1'b0;
      hold <= 1'b0;
      settle(100);
      chk({31'h0, recs.size() >= 2}, 32'h1);
      if (recs.size() >= 2) chk({recs[0].s.addr, recs[1].s.addr}, 32'h00000001);
      rd({24'h0, A_STATUS}, 32'h14);
   endtask : t_stall

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      go = 1'b0;
      hold = 1'b0;
      mode = 2'h0;
      cyc = 3'h0;
      acq_ready = 1'b0;
      fail_count = 0;
      checks = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_example();
      t_stop();
      t_stall();
      final_report();
   end
endmodule : test_acquisition_qualify_sequencer
